// file: dv/sba_monitor.sv
// Checker: assertions on the arbitration and parity pin group
`timescale 1ns/1ps
module sba_monitor (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               rst,
  // Requests and grants
  input wire logic               ext_master_req_b,
  input wire logic               ext_master_req_c,
  input wire logic               ext_addr_grant_b,
  input wire logic               ext_addr_grant_c,
  input wire logic               ext_data_grant_b,
  input wire logic               ext_data_grant_c,
  // Data drive of both parties
  input wire sba_pkg::sba_data_t dev_d_o,
  input wire logic               dev_d_oe,
  input wire sba_pkg::sba_par_t  dev_p_o,
  input wire sba_pkg::sba_data_t mst_d_o,
  input wire logic               mst_d_oe,
  input wire sba_pkg::sba_par_t  mst_p_o
);
  import sba_pkg::*;
  // ****************************************
  // Lane check and properties
  // ****************************************
  // True when every lane plus its parity bit holds an odd count
  function automatic logic odd_ok(sba_data_t d, sba_par_t p);
    odd_ok = 1'b1;
    for (int i = 0; i < LANES; i++) begin
      if (!(^{p[i], d[i*LANE_W +: LANE_W]})) odd_ok = 1'b0;
    end
  endfunction
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_dev_par_odd: assert property (
    dev_d_oe |-> odd_ok(dev_d_o, dev_p_o))
    else $error("device beat parity not odd");
  a_mst_par_odd: assert property (
    mst_d_oe |-> odd_ok(mst_d_o, mst_p_o))
    else $error("master beat parity not odd");
  a_addr_one_owner: assert property (
    !(ext_addr_grant_b && ext_addr_grant_c))
    else $error("two address owners");
  a_data_one_owner: assert property (
    !(ext_data_grant_b && ext_data_grant_c))
    else $error("two data owners");
  // Pin to grant is two sync stages plus one decision flop
  a_grant_needs_req: assert property (
    $rose(ext_addr_grant_b) |-> $past(ext_master_req_b, 3))
    else $error("grant without request");
  a_grant_c_req: assert property (
    $rose(ext_addr_grant_c) |-> $past(ext_master_req_c, 3))
    else $error("grant c without request");
  a_req_gets_grant: assert property (
    $rose(ext_master_req_b) && !ext_master_req_c && !ext_addr_grant_c
    |-> ##[1:3] ext_addr_grant_b)
    else $error("free bus not granted");
  a_data_follows: assert property (
    $rose(ext_addr_grant_b) |=> ext_data_grant_b)
    else $error("data grant late");
  a_grant_released: assert property (
    $fell(ext_master_req_b)
    |-> ##[1:3] !ext_addr_grant_b && !ext_data_grant_b)
    else $error("grant kept after release");
  a_dev_yields: assert property (
    ext_data_grant_b || ext_data_grant_c |-> !dev_d_oe)
    else $error("device drives under master");
endmodule

// file: dv/sysbus_arbitration_parity_test.sv
// Testbench: both ends joined, data beats and ownership hand-over
`timescale 1ns/1ps
module sysbus_arbitration_parity_test;
  import sba_pkg::*;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic      core_clk = 1'b0;     // Core clock
  logic      rst = 1'b1;          // Reset
  logic      int_wr_valid = 1'b0; // Device drive request
  sba_data_t int_wr_data = '0;    // Device drive data
  sba_vec_t  want = '0;           // Master ownership wishes
  logic      wr_valid = 1'b0;     // Master drive request
  sba_data_t wr_data = '0;        // Master drive data
  sba_vec_t  owner_addr, owner_data, have_data;
  logic      dev_perr, mst_perr;  // Parity error pulses
  logic      perr_seen = 1'b0;    // Sticky, pulses are one cycle
  int        num_errors = 0;
  int        n_checks = 0;
  sba_data_t pat [4] = '{64'h0, 64'hffff_ffff_ffff_ffff,
                         64'h0102_0408_1020_4080, 64'h00ff_0f0f_3355_a596};
  sba_if bus();
  sba_arbiter u_sba_arbiter (.core_clk, .rst, .bus, .int_wr_valid,
    .int_wr_data, .par_err(dev_perr), .owner_addr, .owner_data);
  sba_master u_sba_master (.core_clk, .rst, .bus, .want, .wr_valid,
    .wr_data, .have_data, .par_err(mst_perr));
  sba_monitor u_sba_monitor (.core_clk, .rst,
    .ext_master_req_b(bus.ext_master_req_b),
    .ext_master_req_c(bus.ext_master_req_c),
    .ext_addr_grant_b(bus.ext_addr_grant_b),
    .ext_addr_grant_c(bus.ext_addr_grant_c),
    .ext_data_grant_b(bus.ext_data_grant_b),
    .ext_data_grant_c(bus.ext_data_grant_c),
    .dev_d_o(bus.dev_d_o), .dev_d_oe(bus.dev_d_oe), .dev_p_o(bus.dev_p_o),
    .mst_d_o(bus.mst_d_o), .mst_d_oe(bus.mst_d_oe), .mst_p_o(bus.mst_p_o));
  // Clock generator
  always #2 core_clk = ~core_clk;
  // Catch either end flagging a parity fault
  always @(posedge core_clk) begin
    if (dev_perr === 1'b1 || mst_perr === 1'b1) perr_seen <= 1'b1;
  end
  // ****************************************
  // Tasks
  // ****************************************
  // Expected odd lane parity, worked out here
  function automatic sba_par_t odd_lanes(sba_data_t d);
    for (int i = 0; i < LANES; i++) odd_lanes[i] = ~(^d[8*i +: 8]);
  endfunction
  task end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task timeout;
    num_errors++;
    end_sim;
  endtask
  // Wait for master m to hold the data bus
  task wait_own(input int m);
    for (int i = 0; i < 30; i++) begin
      @(posedge core_clk);
      #1;
      if (have_data[m] === 1'b1 && owner_data[m] === 1'b1) return;
    end
    timeout;
  endtask
  // One beat by master (mst=1) or device, then check the wire
  task beat(input bit mst, input sba_data_t d);
    @(posedge core_clk);
    if (mst) begin
      wr_valid <= 1'b1;
      wr_data  <= d;
    end else begin
      int_wr_valid <= 1'b1;
      int_wr_data  <= d;
    end
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      #1;
      if ((mst ? bus.mst_d_oe : bus.dev_d_oe) === 1'b1) begin
        chk(bus.d_i, d);
        chk(64'(bus.p_i), 64'(odd_lanes(d)));
        // Withdraw on the next edge; one repeated beat is harmless
        @(posedge core_clk);
        wr_valid     <= 1'b0;
        int_wr_valid <= 1'b0;
        return;
      end
    end
    timeout;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(64'(owner_addr), 64'h0);
    for (int i = 0; i < 4; i++) beat(1'b0, pat[i]);
    want <= 2'b01;
    wait_own(IDX_B);
    chk(64'(owner_addr), 64'h1);
    beat(1'b1, pat[2]);
    beat(1'b1, pat[3]);
    want <= 2'b11;
    repeat (6) @(posedge core_clk);
    #1;
    chk(64'(owner_addr), 64'h1);
    @(posedge core_clk);
    want <= 2'b10;
    wait_own(IDX_C);
    chk(64'(owner_addr), 64'h2);
    beat(1'b1, pat[1]);
    want <= 2'b00;
    beat(1'b0, pat[2]);
    chk(64'(perr_seen), 64'h0);
    end_sim;
  end
endmodule

// file: hw/sba_arbiter.sv
// Device end: internal arbiter for external masters plus data/parity drive
`timescale 1ns/1ps
module sba_arbiter (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Pin group
  sba_if.dev                    bus,
  // Internal agent: drive data when the device owns the data bus
  input  wire logic             int_wr_valid,
  input  wire sba_pkg::sba_data_t int_wr_data,
  // Parity check result and address/data owner vectors
  output logic                  par_err,
  output sba_pkg::sba_vec_t     owner_addr,
  output sba_pkg::sba_vec_t     owner_data
);
  import sba_pkg::*;

  // ***********************************************************
  // Elaboration checks
  // ***********************************************************
  // Round robin and one-bit fairness pointer serve exactly two masters
  if (MASTERS != 2) begin : g_chk_masters
    $error("arbiter serves exactly two masters");
  end
  // Request concatenation puts master b low and master c high
  if (IDX_B != 0 || IDX_C != 1) begin : g_chk_index
    $error("master index order not supported");
  end
  // Parity is worked out per whole byte lane only
  if (DATA_W != LANES*LANE_W) begin : g_chk_lanes
    $error("data width is not whole byte lanes");
  end

  // ***********************************************************
  // Request synchronisers
  // ***********************************************************
  sba_vec_t req_s1_reg, req_s2_reg;  // Two flops, pins are async
  // Requests may come from another board clock, so two stages first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_s1_reg <= '0;
      req_s2_reg <= '0;
    end else begin
      // Master b in the low bit, c in the high bit
      req_s1_reg <= {bus.ext_master_req_c, bus.ext_master_req_b};
      req_s2_reg <= req_s1_reg;
    end
  end

  // ***********************************************************
  // Arbitration state
  // ***********************************************************
  typedef enum logic [2:0] {
    SBA_IDLE = 3'h1,   // Device owns both buses
    SBA_ADDR = 3'h2,   // Address bus granted
    SBA_DATA = 3'h4    // Address and data bus granted
  } sba_state_e;

  sba_state_e state_reg, state_next;
  // Grant vectors: bit IDX_B for master b, bit IDX_C for master c
  sba_vec_t   ga_reg, ga_next;       // Address grant, one-hot or zero
  sba_vec_t   gd_reg, gd_next;       // Data grant, one-hot or zero
  logic       last_reg, last_next;   // Last master served, for fairness

  // Next-state: round robin, one grant per bus, dropped when request drops
  always_comb begin
    state_next = state_reg;
    ga_next    = ga_reg;
    gd_next    = gd_reg;
    last_next  = last_reg;
    case (state_reg)
      SBA_IDLE: begin
        // Prefer the master not served last time
        if (req_s2_reg[~last_reg]) begin
          ga_next    = '0;
          ga_next[~last_reg] = 1'b1;
          last_next  = ~last_reg;
          state_next = SBA_ADDR;
        end else if (req_s2_reg[last_reg]) begin
          ga_next    = '0;
          ga_next[last_reg] = 1'b1;
          state_next = SBA_ADDR;
        end
      end
      SBA_ADDR: begin
        if ((req_s2_reg & ga_reg) == '0) begin
          ga_next    = '0;               // Request gone: reclaim
          state_next = SBA_IDLE;
        end else begin
          gd_next    = ga_reg;           // Data follows address
          state_next = SBA_DATA;
        end
      end
      SBA_DATA: begin
        // Hold both grants while the owner still asks
        if ((req_s2_reg & gd_reg) == '0) begin
          ga_next    = '0;               // Release both at once
          gd_next    = '0;
          state_next = SBA_IDLE;
        end
      end
      default: begin
        // Illegal code: drop every grant and restart from idle
        ga_next    = '0;
        gd_next    = '0;
        state_next = SBA_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SBA_IDLE;
      ga_reg    <= '0;
      gd_reg    <= '0;
      last_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      ga_reg    <= ga_next;
      gd_reg    <= gd_next;
      last_reg  <= last_next;
    end
  end

  // ***********************************************************
  // Data drive: device drives only while no master owns data
  // ***********************************************************
  sba_data_t dout_reg, dout_next;
  sba_par_t  pout_reg, pout_next;
  logic      doe_reg, doe_next;

  // Next values of the device drive, enable low unless asked for
  always_comb begin
    dout_next = dout_reg;
    pout_next = pout_reg;
    doe_next  = 1'b0;
    // Never drive in the cycle a data grant goes out, avoids contention
    if (int_wr_valid && gd_next == '0 && gd_reg == '0) begin
      dout_next = int_wr_data;
      // Odd parity per lane
      pout_next = sba_odd_par(int_wr_data);
      doe_next  = 1'b1;
    end
  end

  // Registers only; idle parity of all ones is odd over zero data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dout_reg <= '0;
      pout_reg <= '1;
      doe_reg  <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      pout_reg <= pout_next;
      doe_reg  <= doe_next;
    end
  end

  // ***********************************************************
  // Parity check of master-driven beats (same clock bus)
  // ***********************************************************
  logic perr_reg, perr_next;
  // Only beats that the device did not drive are judged here
  always_comb begin
    perr_next = 1'b0;
    if (bus.mst_d_oe && !doe_reg) begin
      perr_next = (sba_odd_par(bus.d_i) != bus.p_i);
    end
  end
  // Registers only, the flag is a one-cycle pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) perr_reg <= 1'b0;
    else     perr_reg <= perr_next;
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  // Every pin below comes straight from a flop, so no glitches
  assign bus.ext_addr_grant_b = ga_reg[IDX_B];
  assign bus.ext_addr_grant_c = ga_reg[IDX_C];
  assign bus.ext_data_grant_b = gd_reg[IDX_B];
  assign bus.ext_data_grant_c = gd_reg[IDX_C];
  assign bus.dev_d_o  = dout_reg;
  assign bus.dev_p_o  = pout_reg;
  assign bus.dev_d_oe = doe_reg;
  assign par_err      = perr_reg;
  assign owner_addr   = ga_reg;
  assign owner_data   = gd_reg;
endmodule

// file: hw/sba_if.sv
// Interface: pin group joining the arbiter end and an external master end
`timescale 1ns/1ps
interface sba_if;
  import sba_pkg::*;
  // Requests and grants
  logic ext_master_req_b;
  logic ext_master_req_c;
  logic ext_addr_grant_b;
  logic ext_addr_grant_c;
  logic ext_data_grant_b;
  logic ext_data_grant_c;
  // Data bus, device side drive
  sba_data_t dev_d_o;
  logic      dev_d_oe;
  sba_par_t  dev_p_o;
  // Data bus, master side drive
  sba_data_t mst_d_o;
  logic      mst_d_oe;
  sba_par_t  mst_p_o;
  // Resolved wire level (single driver assumed)
  sba_data_t d_i;
  sba_par_t  p_i;
  assign d_i = dev_d_oe ? dev_d_o : (mst_d_oe ? mst_d_o : '0);
  assign p_i = dev_d_oe ? dev_p_o : (mst_d_oe ? mst_p_o : '1);

  modport dev (
    input  ext_master_req_b, ext_master_req_c, mst_d_o, mst_d_oe,
    input  mst_p_o, d_i, p_i,
    output ext_addr_grant_b, ext_addr_grant_c, ext_data_grant_b,
    output ext_data_grant_c, dev_d_o, dev_d_oe, dev_p_o
  );
  modport mst (
    output ext_master_req_b, ext_master_req_c, mst_d_o, mst_d_oe,
    output mst_p_o,
    input  d_i, p_i, dev_d_o, dev_d_oe, dev_p_o,
    input  ext_addr_grant_b, ext_addr_grant_c, ext_data_grant_b,
    input  ext_data_grant_c
  );
endinterface

// file: hw/sba_master.sv
// Far end: two external masters requesting the bus and driving data
`timescale 1ns/1ps
module sba_master (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Pin group
  sba_if.mst                      bus,
  // User side: hold want high to own the bus
  input  wire sba_pkg::sba_vec_t  want,
  input  wire logic               wr_valid,
  input  wire sba_pkg::sba_data_t wr_data,
  // Grant status seen, and parity error on device beats
  output sba_pkg::sba_vec_t       have_data,
  output logic                    par_err
);
  import sba_pkg::*;

  // ***********************************************************
  // Grant synchronisers
  // ***********************************************************
  sba_vec_t gd_s1_reg, gd_s2_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gd_s1_reg <= '0;
      gd_s2_reg <= '0;
    end else begin
      gd_s1_reg <= {bus.ext_data_grant_c, bus.ext_data_grant_b};
      gd_s2_reg <= gd_s1_reg;
    end
  end

  // ***********************************************************
  // Requests, data drive and check
  // ***********************************************************
  sba_vec_t  req_reg, req_next;
  sba_data_t d_reg, d_next;
  sba_par_t  p_reg, p_next;
  logic      oe_reg, oe_next;
  logic      perr_reg, perr_next;

  // Drive only while granted data bus and still requesting
  always_comb begin
    req_next  = want;
    d_next    = d_reg;
    p_next    = p_reg;
    oe_next   = 1'b0;
    perr_next = 1'b0;
    if (wr_valid && (gd_s2_reg & want) != '0) begin
      d_next  = wr_data;
      p_next  = sba_odd_par(wr_data);
      oe_next = 1'b1;
    end
    if (bus.dev_d_oe) begin
      perr_next = (sba_odd_par(bus.d_i) != bus.p_i);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_reg  <= '0;
      d_reg    <= '0;
      p_reg    <= '1;
      oe_reg   <= 1'b0;
      perr_reg <= 1'b0;
    end else begin
      req_reg  <= req_next;
      d_reg    <= d_next;
      p_reg    <= p_next;
      oe_reg   <= oe_next;
      perr_reg <= perr_next;
    end
  end

  assign bus.ext_master_req_b = req_reg[IDX_B];
  assign bus.ext_master_req_c = req_reg[IDX_C];
  assign bus.mst_d_o  = d_reg;
  assign bus.mst_p_o  = p_reg;
  assign bus.mst_d_oe = oe_reg;
  assign have_data    = gd_s2_reg;
  assign par_err      = perr_reg;
endmodule

// file: hw/sba_pkg.sv
// Package: shared constants for the system-bus arbitration and parity ends
package sba_pkg;
  // ***********************************************************
  // Bus geometry
  // ***********************************************************
  localparam int DATA_W  = 64;             // Data bus width
  localparam int LANE_W  = 8;              // Bits per byte lane
  localparam int LANES   = DATA_W/LANE_W;  // Parity lanes
  localparam int MASTERS = 2;              // External masters b and c
  localparam int IDX_B   = 0;              // Master b index
  localparam int IDX_C   = 1;              // Master c index

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef logic [DATA_W-1:0] sba_data_t;   // Data word
  typedef logic [LANES-1:0]  sba_par_t;    // Parity lanes
  typedef logic [MASTERS-1:0] sba_vec_t;   // One bit per master

  // Odd parity bit for each byte lane
  function automatic sba_par_t sba_odd_par(input sba_data_t d);
    sba_par_t p;
    p = '0;
    for (int i = 0; i < LANES; i++) begin
      p[i] = ~(^d[i*LANE_W +: LANE_W]);
    end
    return p;
  endfunction
endpackage
